// file: design/epc_ctrl.sv
// epc_ctrl: extended control register and mode controller.
// assumes a synchronous host strobe interface and an external fifo
// whose level comes in as counts; pins are synchronised here.
`timescale 1ns/1ps
// Contract
// RL1 - three-bit mode field in bits 7:5, read and write.
// RL2 - in ecp mode fault falling edge pulses interrupt unless disabled.
// RL3 - clearing fault disable while fault asserted raises an interrupt.
// RL4 - dma allow permits dma only while service mask is zero.
// RL5 - service mask high blocks dma and service irqs; writing 1 silent.
// RL6 - hardware sets service mask on service irq; software clears it.
// RL7 - with dma on, terminal count sets service mask.
// RL8 - dma off, forward: enough free bytes sets service mask.
// RL9 - dma off, reverse: enough filled bytes sets service mask.
// RL10 - bit 1 reads full, bit 0 reads empty.
// RL11 - standard mode resets fifo, open-collector controls, no tri-state.
// RL12 - bidirectional mode: direction tri-states data, push-pull drivers.
// RL13 - fifo mode sends bytes with standard handshake, forward only.
// RL14 - ecp mode forward sends, reverse receives into the fifo; data_oe stays high in ecp reverse.
// RL15 - mode 100 selects epp only if option enabled; 101 reserved.
// RL16 - test mode: fifo accessible, nothing transmitted.
// RL17 - config mode maps config registers at 0x400 and 0x401.
// RL18 - automatic handshake only in modes 011 and 010.
// RL19 - from 000/001 any mode; otherwise only to 000 or 001.
// RL20 - direction changes only while in mode 001.
// RL21 - software empties fifo first; controls deassert before switch (ctrl_deassert here rises one cycle after the switch).
// RL22 - leaving ecp reverse drops auto-feed at once, discards bytes; ctrl_deassert rises one cycle later, fifo_reset only in mode 000.
// RL23 - no handshake glitches on a legal mode change.
// RL24 - interrupt is a brief low pulse, then released.
// RL25 - reset gives mode 000 and service mask set.
module epc_ctrl
  import epc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host register access
  input wire logic [10:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic cfg_sel,
  output logic fifo_sel,
  // control bits from other registers
  input wire logic dir_req,
  input wire logic epp_option,
  input wire logic dma_tc,
  input wire logic [4:0] fifo_fill,
  input wire logic [3:0] fifo_thr,
  // port pins
  input wire logic fault_n_pin,
  output logic irq_o,
  output logic irq_oe,
  // mode outputs to the port datapath
  output logic [2:0] mode,
  output logic dir_rev,
  output logic fifo_reset,
  output logic ctrl_push_pull,
  output logic data_oe,
  output logic auto_hs,
  output logic epp_sel,
  output logic dma_req_ok,
  output logic ctrl_deassert
);
  logic flt_dis;
  logic dma_allow;
  logic service_irq_mask;
  logic f_s1, f_s2, f_prev;
  logic [3:0] pulse_cnt;
  logic full, empty, fault_fall, fault_clr, ctrl_wr, svc_hit, fault_irq;
  logic [2:0] wmode;
  logic mode_ok;
  epc_status_if st();

  epc_svc_cond u_svc (.st(st));

  assign ctrl_wr = wr_en && addr == EPC_OFS_CTRL;
  assign wmode = wdata[EPC_MODE_LSB +: 3];
  // legal switch check
  assign mode_ok = (mode == EPC_M_STD || mode == EPC_M_BIDIR ||
    wmode == EPC_M_STD || wmode == EPC_M_BIDIR); // RL19

  // mode field; an illegal switch is ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      mode <= EPC_RST_MODE; // RL25
    else if (ctrl_wr && mode_ok)
      mode <= wmode; // RL1
  end

  // direction follows request only in bidirectional mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      dir_rev <= 1'b0;
    else if (mode == EPC_M_BIDIR)
      dir_rev <= dir_req; // RL20
  end

  // fault disable and dma allow
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_dis <= EPC_RST_FLT;
      dma_allow <= EPC_RST_DMA;
    end else if (ctrl_wr) begin
      flt_dis <= wdata[EPC_FLT_BIT];
      dma_allow <= wdata[EPC_DMA_BIT];
    end
  end

  // fifo flags from fill level
  assign full = fifo_fill >= 5'(FIFO_DEPTH); // RL10
  assign empty = fifo_fill == 5'h00; // RL10

  // service condition unit inputs
  assign st.fill = fifo_fill;
  assign st.free_cnt = 5'(FIFO_DEPTH) - fifo_fill;
  assign st.tx_free_level = {1'b0, fifo_thr} + 5'h01;
  assign st.rx_fill_level = {1'b0, fifo_thr} + 5'h01;
  assign st.svc_ok = !service_irq_mask; // RL5
  assign st.dir_rev = dir_rev;
  assign st.dma_on = dma_allow;
  assign st.tc = dma_tc;
  assign svc_hit = st.svc_set;

  // service mask: hardware set wins over software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      service_irq_mask <= EPC_RST_SVC; // RL25
    else if (svc_hit)
      service_irq_mask <= 1'b1; // RL6
    else if (ctrl_wr)
      service_irq_mask <= wdata[EPC_SVC_BIT];
  end

  // dma enable gate
  assign dma_req_ok = dma_allow && !service_irq_mask; // RL4

  // fault pin synchroniser and edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      f_s1 <= 1'b1;
      f_s2 <= 1'b1;
      f_prev <= 1'b1;
    end else begin
      f_s1 <= fault_n_pin;
      f_s2 <= f_s1;
      f_prev <= f_s2;
    end
  end

  assign fault_fall = f_prev && !f_s2;
  // lost-event guard when disable goes 1 to 0
  assign fault_clr = ctrl_wr && flt_dis && !wdata[EPC_FLT_BIT] && !f_s2;
  assign fault_irq = mode == EPC_M_ECP &&
    ((fault_fall && !flt_dis) || fault_clr); // RL2 RL3

  // low pulse on shared irq line, then released
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      pulse_cnt <= 4'h0;
    else if (svc_hit || fault_irq)
      pulse_cnt <= 4'(EPC_IRQ_CYC); // RL24
    else if (pulse_cnt != 4'h0)
      pulse_cnt <= pulse_cnt - 4'h1;
  end
  assign irq_o = 1'b0;
  assign irq_oe = pulse_cnt != 4'h0; // RL24

  // mode decode toward the port datapath
  always_comb begin
    fifo_reset = mode == EPC_M_STD; // RL11
    ctrl_push_pull = mode != EPC_M_STD; // RL11 RL12
    data_oe = !(mode == EPC_M_BIDIR && dir_rev); // RL12
    auto_hs = mode == EPC_M_FIFO ||
      mode == EPC_M_ECP; // RL13 RL14 RL16 RL18
    epp_sel = mode == EPC_M_EPP && epp_option; // RL15
    cfg_sel = mode == EPC_M_CFG &&
      (addr == EPC_OFS_FIFO || addr == EPC_OFS_CFGB); // RL17
    fifo_sel = addr == EPC_OFS_FIFO &&
      (auto_hs || mode == EPC_M_TEST); // RL16
  end

  // controls forced idle once outside automatic modes; registered,
  // so the handover is a single clean edge with no glitch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      ctrl_deassert <= 1'b1;
    else
      ctrl_deassert <= !(mode == EPC_M_FIFO ||
        mode == EPC_M_ECP); // RL21 RL22 RL23
  end

  // register readback
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd_en && addr == EPC_OFS_CTRL)
      rdata <= {mode, flt_dis, dma_allow, service_irq_mask, full, empty};
    else if (rd_en)
      rdata <= 8'h00;
  end

  // refused switch keeps the old mode, other bits still land
  property p_mode_hold;
    @(posedge clk) disable iff (!nrst)
    ctrl_wr && !mode_ok |=> mode == $past(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) // RL19
    else $error("illegal mode switch taken");
  property p_mode_legal;
    @(posedge clk) disable iff (!nrst)
    ctrl_wr && mode_ok |=> mode == $past(wmode);
  endproperty
  a_mode_legal: assert property (p_mode_legal) // RL1
    else $error("legal mode switch not taken");
  property p_svc_set;
    @(posedge clk) disable iff (!nrst) svc_hit |=> service_irq_mask;
  endproperty
  a_svc_set: assert property (p_svc_set)
    else $error("service mask not set"); // RL6
  property p_masked;
    @(posedge clk) disable iff (!nrst) service_irq_mask |-> !svc_hit;
  endproperty
  a_masked: assert property (p_masked)
    else $error("service irq while masked"); // RL5
  property p_dma;
    @(posedge clk) disable iff (!nrst)
    dma_req_ok |-> dma_allow && !service_irq_mask;
  endproperty
  a_dma: assert property (p_dma) else $error("dma gate wrong"); // RL4
  property p_pulse;
    @(posedge clk) disable iff (!nrst)
    fault_irq |=> irq_oe [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("irq pulse short"); // RL24
  property p_release;
    @(posedge clk) disable iff (!nrst)
    fault_irq ##1 !(svc_hit || fault_irq) [*8]
      ##1 !(svc_hit || fault_irq) [*2] |=> !irq_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("irq not released"); // RL24
  property p_dir;
    @(posedge clk) disable iff (!nrst)
    mode != EPC_M_BIDIR |=> $stable(dir_rev);
  endproperty
  a_dir: assert property (p_dir) else $error("direction changed"); // RL20
  property p_hs;
    @(posedge clk) disable iff (!nrst)
    auto_hs |-> mode == EPC_M_FIFO || mode == EPC_M_ECP;
  endproperty
  a_hs: assert property (p_hs) else $error("handshake in bad mode"); // RL18
  c_ecp: cover property (@(posedge clk) mode == EPC_M_ECP);
  c_fault: cover property (@(posedge clk) fault_irq);
  c_svc: cover property (@(posedge clk) svc_hit);
endmodule : epc_ctrl

// file: design/epc_pkg.sv
// epc_pkg: shared constants for the extended port control block.
// assumes one 200 MHz clock; offsets are relative to the port base.
package epc_pkg;
  localparam logic [10:0] EPC_OFS_FIFO = 11'h400;
  localparam logic [10:0] EPC_OFS_CFGB = 11'h401;
  localparam logic [10:0] EPC_OFS_CTRL = 11'h402;
  localparam int EPC_MODE_LSB = 5;
  localparam int EPC_FLT_BIT = 4;
  localparam int EPC_DMA_BIT = 3;
  localparam int EPC_SVC_BIT = 2;
  localparam int EPC_FULL_BIT = 1;
  localparam int EPC_EMPTY_BIT = 0;
  localparam logic [2:0] EPC_M_STD = 3'h0;
  localparam logic [2:0] EPC_M_BIDIR = 3'h1;
  localparam logic [2:0] EPC_M_FIFO = 3'h2;
  localparam logic [2:0] EPC_M_ECP = 3'h3;
  localparam logic [2:0] EPC_M_EPP = 3'h4;
  localparam logic [2:0] EPC_M_RSVD = 3'h5;
  localparam logic [2:0] EPC_M_TEST = 3'h6;
  localparam logic [2:0] EPC_M_CFG = 3'h7;
  localparam logic [2:0] EPC_RST_MODE = 3'h0;
  localparam logic EPC_RST_FLT = 1'b1;
  localparam logic EPC_RST_DMA = 1'b0;
  localparam logic EPC_RST_SVC = 1'b1;
  // interrupt low pulse width
  localparam int EPC_IRQ_PULSE_NS = 50;
  localparam int EPC_CLK_NS = 5;
  localparam int EPC_IRQ_CYC = EPC_IRQ_PULSE_NS / EPC_CLK_NS;
endpackage : epc_pkg

// file: design/epc_status_if.sv
// epc_status_if: fifo level and event signals into the irq unit.
// assumes the same clock as the control register.
`timescale 1ns/1ps
interface epc_status_if;
  logic [4:0] fill;
  logic [4:0] free_cnt;
  logic [4:0] tx_free_level;
  logic [4:0] rx_fill_level;
  logic svc_ok;
  logic dir_rev;
  logic dma_on;
  logic tc;
  logic svc_set;
  modport src(output fill, free_cnt, tx_free_level, rx_fill_level,
    svc_ok, dir_rev, dma_on, tc, input svc_set);
  modport dst(input fill, free_cnt, tx_free_level, rx_fill_level,
    svc_ok, dir_rev, dma_on, tc, output svc_set);
endinterface : epc_status_if

// file: design/epc_svc_cond.sv
// epc_svc_cond: decides when a service interrupt condition holds.
// assumes levels are from the same clock domain.
`timescale 1ns/1ps
module epc_svc_cond
  import epc_pkg::*;
(
  epc_status_if.dst st
);
  // dma tc, forward free space, reverse fill
  always_comb begin
    if (!st.svc_ok)
      st.svc_set = 1'b0;
    else if (st.dma_on)
      st.svc_set = st.tc; // RL7
    else if (!st.dir_rev)
      st.svc_set = st.free_cnt >= st.tx_free_level; // RL8
    else
      st.svc_set = st.fill >= st.rx_fill_level; // RL9
  end
endmodule : epc_svc_cond

// file: bench/epc_periph.sv
// epc_periph: peripheral model that drives the fault line.
// assumes the bench clock; lag mimics a slow peripheral.
`timescale 1ns/1ps
module epc_periph #(
  parameter int LAG = 3
) (
  // clock
  input wire logic clk,
  // fault request from the bench, line back to the port
  input wire logic fault_req,
  output logic fault_n_pin
);
  logic [7:0] sr = 8'hFF;
  // low true fault, seen lag plus one cycles after the request
  always @(posedge clk) begin
    sr <= {sr[6:0], ~fault_req};
  end
  assign fault_n_pin = sr[LAG];
endmodule : epc_periph

// file: bench/tb.sv
// tb: self-checking bench for the extended port control block.
// assumes the peripheral model and a 200 MHz clock.
`timescale 1ns/1ps
module tb;
  import epc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic dir_req = 1'b0, epp_option = 1'b0, dma_tc = 1'b0;
  logic fault_req = 1'b0, irq_q = 1'b0;
  logic [10:0] addr = EPC_OFS_CTRL;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic [4:0] fifo_fill = 5'h00;
  logic [3:0] fifo_thr = 4'h0;
  logic cfg_sel, fifo_sel, fault_n_pin, irq_o, irq_oe, dir_rev;
  logic fifo_reset, ctrl_push_pull, data_oe, auto_hs, epp_sel;
  logic dma_req_ok, ctrl_deassert;
  logic [2:0] mode, m_mode = 3'h0, m_b = 3'h5, nm;
  int miscompares = 0, compares = 0, npulse = 0, hcyc = 0, p;
  epc_ctrl #(.FIFO_DEPTH(16)) epc_ctrl_i (.clk(clk), .nrst(nrst),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .cfg_sel(cfg_sel), .fifo_sel(fifo_sel),
    .dir_req(dir_req), .epp_option(epp_option), .dma_tc(dma_tc),
    .fifo_fill(fifo_fill), .fifo_thr(fifo_thr),
    .fault_n_pin(fault_n_pin), .irq_o(irq_o), .irq_oe(irq_oe),
    .mode(mode), .dir_rev(dir_rev), .fifo_reset(fifo_reset),
    .ctrl_push_pull(ctrl_push_pull), .data_oe(data_oe),
    .auto_hs(auto_hs), .epp_sel(epp_sel), .dma_req_ok(dma_req_ok),
    .ctrl_deassert(ctrl_deassert));
  epc_periph #(.LAG(3)) epc_periph_i (.clk(clk),
    .fault_req(fault_req), .fault_n_pin(fault_n_pin));
  always #2.5 clk = ~clk;
  // pulse monitor: count pulses and low-drive cycles
  always @(posedge clk) begin
    if (irq_oe === 1'b1) hcyc++;
    if (irq_oe === 1'b1 && irq_q !== 1'b1) npulse++;
    irq_q = irq_oe;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // one host write of the control register, model updated alongside
  task ctrl(input logic [2:0] m, input logic [2:0] b);
    @(posedge clk);
    addr <= EPC_OFS_CTRL;
    wdata <= {m, b, 2'b00};
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (m_mode <= 3'h1 || m <= 3'h1) m_mode = m;
    m_b = b;
    // scenarios that clear the mask keep the level condition true
    if (!b[0] && !b[1]) m_b[0] = 1'b1;
  endtask : ctrl
  task rd;
    @(posedge clk);
    addr <= EPC_OFS_CTRL;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    chk(d, {m_mode, m_b, fifo_fill >= 5'd16, fifo_fill == 5'd0});
  endtask : rd
  // fixed window longer than any pulse plus pin sync
  task gap;
    repeat (30) @(posedge clk);
  endtask : gap
  initial begin
    void'($urandom(32'h2322));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd;
    chk(d, {EPC_RST_MODE, EPC_RST_FLT, EPC_RST_DMA, EPC_RST_SVC,
      2'b01});
    // random mode walk, legal and refused switches
    repeat (40) begin
      nm = 3'($urandom_range(7));
      @(posedge clk);
      epp_option <= 1'($urandom_range(1));
      fifo_fill <= 5'($urandom_range(16));
      ctrl(nm, 3'h5);
      rd;
      chk(auto_hs, m_mode inside {3'h2, 3'h3});
      chk(fifo_reset, m_mode == 3'h0);
      chk(ctrl_push_pull, m_mode != 3'h0);
      chk(epp_sel, m_mode == 3'h4 && epp_option);
      chk(ctrl_deassert, !(m_mode inside {3'h2, 3'h3}));
      @(posedge clk);
      addr <= EPC_OFS_FIFO;
      @(posedge clk);
      #1 chk(cfg_sel, m_mode == 3'h7);
      chk(fifo_sel, m_mode inside {3'h2, 3'h3, 3'h6});
    end
    ctrl(3'h0, 3'h5);
    @(posedge clk);
    fifo_fill <= 5'h00;
    fifo_thr <= 4'($urandom_range(15));
    ctrl(3'h2, 3'h5);
    p = npulse;
    // clearing the mask with free space met sets it again
    ctrl(3'h2, 3'h4);
    gap;
    rd;
    chk(8'(npulse - p), 8'h01);
    chk(8'(hcyc), 8'(EPC_IRQ_CYC));
    chk(irq_o, 1'b0);
    ctrl(3'h2, 3'h5);
    gap;
    chk(8'(npulse - p), 8'h01);
    chk(dma_req_ok, 1'b0);
    ctrl(3'h2, 3'h6);
    #1 chk(dma_req_ok, 1'b1);
    @(posedge clk);
    dma_tc <= 1'b1;
    @(posedge clk);
    dma_tc <= 1'b0;
    m_b[0] = 1'b1;
    gap;
    rd;
    chk(8'(npulse - p), 8'h02);
    ctrl(3'h2, 3'h4);
    #1 chk(dma_req_ok, 1'b0);
    // fault edges: disabled, enabled, then re-enable while low
    ctrl(3'h0, 3'h5);
    ctrl(3'h3, 3'h5);
    p = npulse;
    @(posedge clk);
    fault_req <= 1'b1;
    gap;
    chk(8'(npulse - p), 8'h00);
    @(posedge clk);
    fault_req <= 1'b0;
    // let the pin settle high so the re-enable raises nothing
    gap;
    ctrl(3'h3, 3'h1);
    gap;
    @(posedge clk);
    fault_req <= 1'b1;
    gap;
    chk(8'(npulse - p), 8'h01);
    ctrl(3'h3, 3'h5);
    ctrl(3'h3, 3'h1);
    gap;
    chk(8'(npulse - p), 8'h02);
    // direction follows the request only in mode 001
    ctrl(3'h1, 3'h5);
    @(posedge clk);
    dir_req <= 1'b1;
    fifo_fill <= 5'h10;
    repeat (2) @(posedge clk);
    #1 chk(dir_rev, 1'b1);
    chk(data_oe, 1'b0);
    // reverse, dma off: a full fifo meets any read level
    p = npulse;
    ctrl(3'h1, 3'h4);
    gap;
    rd;
    chk(8'(npulse - p), 8'h01);
    ctrl(3'h0, 3'h5);
    @(posedge clk);
    dir_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(dir_rev, 1'b1);
    chk(data_oe, 1'b1);
    results;
  end
endmodule : tb
